// *** logic/sca_alu_top.sv ***
// shift and carry-chain slice of the 8-bit core alu, with its carry flag
// assumes the decoder presents one operation per cycle on opValid and the
// register file takes the registered result on the cycle after
//
// Overview of operation
// - arithmetic right shift copies the top bit back, keeping the sign
// - one left shift inserts zero; the arithmetic left name is the same
// - every shift puts the bit shifted out into carry
// - rotates fill from carry and load carry with the outgoing bit
// - logical right shift inserts zero at the top, low bit to carry
// - subtract with borrow uses the previous byte's borrow
// - rotates are nine bits through carry; nine restore the start
// - the working register may be operand and destination directly
`timescale 1ns/1ps

module sca_alu_top #(
  parameter int WIDTH = sca_pkg::DATA_WIDTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic opValid,
  input wire sca_pkg::sca_op_type opCode,
  input wire logic [WIDTH-1:0] workIn,
  input wire logic [WIDTH-1:0] fileIn,
  input wire logic fileIsWorking,
  input wire logic destWorking,
  input wire logic carryLoad,
  input wire logic carryLoadValue,
  output logic [WIDTH-1:0] resultData,
  output logic resultValid,
  output logic writeWorking,
  output logic writeFile,
  output logic carryFlag,
  output logic zeroFlag
);

  logic [WIDTH-1:0] operand;
  logic [WIDTH-1:0] unitResult;
  logic unitCarry;
  logic toWorking;

  // the working register, seen through its file alias, feeds the operand
  assign operand = fileIsWorking ? workIn : fileIn;
  assign toWorking = destWorking | fileIsWorking;

  sca_shift_unit #(
    .WIDTH(WIDTH)
  ) u_shift (
    .opCode(opCode),
    .workVal(workIn),
    .operandVal(operand),
    .carryIn(carryFlag),
    .resultVal(unitResult),
    .carryOut(unitCarry)
  );

  // carry flag: an executing operation wins over a register-file write,
  // since the alu result is the later event in the instruction
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      carryFlag <= sca_pkg::CARRY_RESET;
    end else if (opValid) begin
      carryFlag <= unitCarry;
    end else if (carryLoad) begin
      carryFlag <= carryLoadValue;
    end
  end

  // result byte and zero flag, registered straight to the outputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      resultData <= sca_pkg::RESULT_RESET;
      zeroFlag <= sca_pkg::ZERO_RESET;
    end else if (opValid) begin
      resultData <= unitResult;
      zeroFlag <= (unitResult == '0);
    end
  end

  // write strobes: one-cycle pulses aligned with the new result
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      resultValid <= 1'b0;
      writeWorking <= 1'b0;
      writeFile <= 1'b0;
    end else begin
      resultValid <= opValid;
      writeWorking <= opValid & toWorking;
      writeFile <= opValid & ~toWorking;
    end
  end

  property p_asr_sign;
    @(posedge ref_clk) disable iff (rst)
      opValid && opCode == sca_pkg::arith_right_shift_op |=>
        resultData[WIDTH-1] == $past(operand[WIDTH-1]) &&
        resultData[WIDTH-2:0] == $past(operand[WIDTH-1:1]);
  endproperty
  a_asr_sign: assert property (p_asr_sign)
    else $error("arithmetic right shift lost the sign bit");

  property p_left_shift;
    @(posedge ref_clk) disable iff (rst)
      opValid && (opCode == sca_pkg::logic_left_shift_op ||
                  opCode == sca_pkg::arith_left_shift_alias) |=>
        resultData == {$past(operand[WIDTH-2:0]), 1'b0} &&
        carryFlag == $past(operand[WIDTH-1]);
  endproperty
  a_left_shift: assert property (p_left_shift)
    else $error("left shift result or carry wrong");

  property p_shift_carry;
    @(posedge ref_clk) disable iff (rst)
      opValid && (opCode == sca_pkg::arith_right_shift_op ||
                  opCode == sca_pkg::logic_right_shift_op) |=>
        carryFlag == $past(operand[0]) && resultValid;
  endproperty
  a_shift_carry: assert property (p_shift_carry)
    else $error("right shift did not move low bit into carry");

  property p_rotate_right;
    @(posedge ref_clk) disable iff (rst)
      opValid && opCode == sca_pkg::rotate_right_thru_carry |=>
        {resultData, carryFlag} == {$past(carryFlag), $past(operand)};
  endproperty
  a_rotate_right: assert property (p_rotate_right)
    else $error("rotate right through carry wrong");

  property p_rotate_left;
    @(posedge ref_clk) disable iff (rst)
      opValid && opCode == sca_pkg::rotate_left_thru_carry |=>
        {carryFlag, resultData} == {$past(operand), $past(carryFlag)};
  endproperty
  a_rotate_left: assert property (p_rotate_left)
    else $error("rotate left through carry wrong");

  property p_logic_right;
    @(posedge ref_clk) disable iff (rst)
      opValid && opCode == sca_pkg::logic_right_shift_op |=>
        resultData == {1'b0, $past(operand[WIDTH-1:1])} &&
        carryFlag == $past(operand[0]);
  endproperty
  a_logic_right: assert property (p_logic_right)
    else $error("logical right shift did not insert zero");

  property p_sub_borrow;
    @(posedge ref_clk) disable iff (rst)
      opValid && opCode == sca_pkg::sub_with_borrow_op |=>
        resultData == WIDTH'($past(operand) - $past(workIn) -
                             WIDTH'(!$past(carryFlag))) &&
        carryFlag == ({1'b0, $past(operand)} >=
                      ({1'b0, $past(workIn)} +
                       (WIDTH+1)'(!$past(carryFlag))));
  endproperty
  a_sub_borrow: assert property (p_sub_borrow)
    else $error("subtract with borrow result or borrow wrong");

  property p_rotate_nine_bits;
    @(posedge ref_clk) disable iff (rst)
      opValid && (opCode == sca_pkg::rotate_right_thru_carry ||
                  opCode == sca_pkg::rotate_left_thru_carry) |=>
        $countones({carryFlag, resultData}) ==
        $countones({$past(carryFlag), $past(operand)});
  endproperty
  a_rotate_nine_bits: assert property (p_rotate_nine_bits)
    else $error("rotate did not preserve the nine-bit ring");

  property p_working_alias;
    @(posedge ref_clk) disable iff (rst)
      opValid && fileIsWorking &&
      opCode == sca_pkg::logic_right_shift_op |=>
        writeWorking && !writeFile &&
        resultData == {1'b0, $past(workIn[WIDTH-1:1])};
  endproperty
  a_working_alias: assert property (p_working_alias)
    else $error("working register alias not used as operand and target");

  property p_add_carry;
    @(posedge ref_clk) disable iff (rst)
      opValid && opCode == sca_pkg::add_with_carry_op |=>
        {carryFlag, resultData} ==
        ({1'b0, $past(workIn)} + {1'b0, $past(operand)} +
         (WIDTH+1)'($past(carryFlag)));
  endproperty
  a_add_carry: assert property (p_add_carry)
    else $error("add with carry result or carry wrong");

  property p_carry_hold;
    @(posedge ref_clk) disable iff (rst)
      !opValid && !carryLoad |=> $stable(carryFlag) && !resultValid;
  endproperty
  a_carry_hold: assert property (p_carry_hold)
    else $error("carry changed without an operation or load");

  // a register-file write of carry must land when no operation runs
  property p_carry_load;
    @(posedge ref_clk) disable iff (rst)
      !opValid && carryLoad |=> carryFlag == $past(carryLoadValue);
  endproperty
  a_carry_load: assert property (p_carry_load)
    else $error("carry load from the register file was lost");

  // after each operation the zero flag describes the byte just registered; reset clears it although the reset byte is zero
  property p_zero_flag;
    @(posedge ref_clk) disable iff (rst)
      opValid |=> zeroFlag == (resultData == '0);
  endproperty
  a_zero_flag: assert property (p_zero_flag)
    else $error("zero flag disagrees with the result byte");

  // each operation gives exactly one write strobe, aimed by destination
  property p_write_target;
    @(posedge ref_clk) disable iff (rst)
      opValid |=> resultValid && (writeWorking != writeFile) &&
        writeWorking == $past(destWorking || fileIsWorking);
  endproperty
  a_write_target: assert property (p_write_target)
    else $error("result strobe or its destination wrong");

  // strobes are single pulses, so a write never repeats on an idle cycle
  property p_strobe_single;
    @(posedge ref_clk) disable iff (rst)
      !opValid |=> !writeWorking && !writeFile;
  endproperty
  a_strobe_single: assert property (p_strobe_single)
    else $error("write strobe without an operation");

endmodule : sca_alu_top

// *** include/sca_pkg.sv ***
// shared constants and types for the shift and carry-chain alu slice
// assumes one core clock and a synchronous active-high core reset
package sca_pkg;

  // operand width of the core datapath
  localparam int DATA_WIDTH = 8;

  // reset values of the flag and result registers
  localparam logic CARRY_RESET = 1'b0;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic [DATA_WIDTH-1:0] RESULT_RESET = 8'h00;

  // fill bit that the plain shifts bring in
  localparam logic SHIFT_FILL = 1'b0;

  // operation codes handed over by the instruction decoder
  typedef enum logic [3:0] {
    arith_right_shift_op,
    logic_right_shift_op,
    logic_left_shift_op,
    arith_left_shift_alias,
    rotate_right_thru_carry,
    rotate_left_thru_carry,
    add_with_carry_op,
    sub_with_borrow_op
  } sca_op_type;

endpackage : sca_pkg

// *** logic/sca_shift_unit.sv ***
// combinational shift, rotate and carry-chain arithmetic for one byte
// assumes operands are already selected and the carry is the live flag
`timescale 1ns/1ps

module sca_shift_unit #(
  parameter int WIDTH = sca_pkg::DATA_WIDTH
) (
  input wire sca_pkg::sca_op_type opCode,
  input wire logic [WIDTH-1:0] workVal,
  input wire logic [WIDTH-1:0] operandVal,
  input wire logic carryIn,
  output logic [WIDTH-1:0] resultVal,
  output logic carryOut
);

  // fill bit for the plain shifts, declared ahead of its first use
  localparam logic SHIFT_FILL_BIT = sca_pkg::SHIFT_FILL;

  logic [WIDTH:0] sumWide;
  logic [WIDTH:0] diffWide;

  // nine-bit wide sums so the carry and borrow out of the top bit survive
  assign sumWide = {1'b0, workVal} + {1'b0, operandVal}
                 + {{WIDTH{1'b0}}, carryIn};
  assign diffWide = {1'b0, operandVal} - {1'b0, workVal}
                  - {{WIDTH{1'b0}}, ~carryIn};

  // one case per operation; carry means "no borrow" for the subtract
  always_comb begin
    resultVal = operandVal;
    carryOut = carryIn;
    case (opCode)
      sca_pkg::arith_right_shift_op: begin
        // top bit copied back so a negative byte stays negative
        resultVal = {operandVal[WIDTH-1], operandVal[WIDTH-1:1]};
        carryOut = operandVal[0];
      end
      sca_pkg::logic_right_shift_op: begin
        resultVal = {SHIFT_FILL_BIT, operandVal[WIDTH-1:1]};
        carryOut = operandVal[0];
      end
      sca_pkg::logic_left_shift_op,
      sca_pkg::arith_left_shift_alias: begin
        // only one left shift exists; the arithmetic name maps onto it
        resultVal = {operandVal[WIDTH-2:0], SHIFT_FILL_BIT};
        carryOut = operandVal[WIDTH-1];
      end
      sca_pkg::rotate_right_thru_carry: begin
        resultVal = {carryIn, operandVal[WIDTH-1:1]};
        carryOut = operandVal[0];
      end
      sca_pkg::rotate_left_thru_carry: begin
        resultVal = {operandVal[WIDTH-2:0], carryIn};
        carryOut = operandVal[WIDTH-1];
      end
      sca_pkg::add_with_carry_op: begin
        resultVal = sumWide[WIDTH-1:0];
        carryOut = sumWide[WIDTH];
      end
      sca_pkg::sub_with_borrow_op: begin
        resultVal = diffWide[WIDTH-1:0];
        carryOut = ~diffWide[WIDTH];
      end
      default: begin
        resultVal = operandVal;
        carryOut = carryIn;
      end
    endcase
  end

endmodule : sca_shift_unit

// *** test/sca_regfile_model.sv ***
// working and file register model that feeds and takes the alu slice
// assumes the write strobes are one-cycle pulses with the result byte
`timescale 1ns/1ps

module sca_regfile_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic loadEn,
  input wire logic [7:0] loadWork,
  input wire logic [7:0] loadFile,
  input wire logic [7:0] resultData,
  input wire logic writeWorking,
  input wire logic writeFile,
  output logic [7:0] workReg,
  output logic [7:0] fileReg
);
  // preload wins, otherwise take results on their strobes; no write
  // happens on the op edge itself, so operands stay put for that cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      workReg <= 8'h00;
      fileReg <= 8'h00;
    end else if (loadEn) begin
      workReg <= loadWork;
      fileReg <= loadFile;
    end else begin
      if (writeWorking) workReg <= resultData;
      if (writeFile) fileReg <= resultData;
    end
  end
endmodule : sca_regfile_model

// *** test/tb.sv ***
// self-checking bench for the shift and carry-chain alu slice
// assumes the register model above supplies both operands
`timescale 1ns/1ps

module tb;
  logic ref_clk = 1'b0, rst = 1'b1, opValid = 1'b0, fiw = 1'b0;
  logic dw = 1'b0, cLoad = 1'b0, cVal = 1'b0, loadEn = 1'b0;
  sca_pkg::sca_op_type opCode = sca_pkg::arith_right_shift_op;
  logic [7:0] lw = 8'h00, lf = 8'h00, workReg, fileReg, resultData;
  logic resultValid, writeWorking, writeFile, carryFlag, zeroFlag;
  int fail_count = 0, compares = 0;
  localparam logic [7:0] SH_RES [8] = '{8'h3F, 8'hC0, 8'h3F, 8'h40,
    8'hFE, 8'h00, 8'hFE, 8'h00};
  localparam logic [7:0] SH_C = 8'hA5;

  // 50 ns core clock
  always #25 ref_clk = ~ref_clk;

  sca_alu_top DUT (.ref_clk(ref_clk), .rst(rst), .opValid(opValid),
    .opCode(opCode), .workIn(workReg), .fileIn(fileReg),
    .fileIsWorking(fiw), .destWorking(dw), .carryLoad(cLoad),
    .carryLoadValue(cVal), .resultData(resultData),
    .resultValid(resultValid), .writeWorking(writeWorking),
    .writeFile(writeFile), .carryFlag(carryFlag), .zeroFlag(zeroFlag));

  sca_regfile_model PEER (.ref_clk(ref_clk), .rst(rst), .loadEn(loadEn),
    .loadWork(lw), .loadFile(lf), .resultData(resultData),
    .writeWorking(writeWorking), .writeFile(writeFile),
    .workReg(workReg), .fileReg(fileReg));

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  // one op; returns a step after the answer edge, strobes still high
  task automatic op(input sca_pkg::sca_op_type c, input logic f,
                    input logic d);
    @(posedge ref_clk);
    opValid <= 1'b1;
    opCode <= c;
    fiw <= f;
    dw <= d;
    @(posedge ref_clk);
    opValid <= 1'b0;
    #1;
  endtask : op

  task automatic setc(input logic v);
    @(posedge ref_clk);
    cLoad <= 1'b1;
    cVal <= v;
    @(posedge ref_clk);
    cLoad <= 1'b0;
  endtask : setc

  task automatic load(input logic [7:0] w, input logic [7:0] f);
    @(posedge ref_clk);
    loadEn <= 1'b1;
    lw <= w;
    lf <= f;
    @(posedge ref_clk);
    loadEn <= 1'b0;
  endtask : load

  // every shift on both table values, carry preset to one
  task automatic shift_table;
    for (int i = 0; i < 8; i++) begin
      load(8'h00, i[0] ? 8'h80 : 8'h7F);
      setc(1'b1);
      op(sca_pkg::sca_op_type'(i >> 1), 1'b0, 1'b0);
      chk8(resultData, SH_RES[i]);
      chk1(carryFlag, SH_C[i]);
      chk1(writeFile, 1'b1);
      chk1(resultValid, 1'b1);
      chk1(zeroFlag, SH_RES[i] == 8'h00);
    end
  endtask : shift_table

  // nine right rotates through carry restore the start
  task automatic rotate_nine;
    load(8'h00, 8'hA5);
    setc(1'b1);
    op(sca_pkg::rotate_right_thru_carry, 1'b0, 1'b0);
    chk8(resultData, 8'hD2);
    chk1(carryFlag, 1'b1);
    repeat (8) op(sca_pkg::rotate_right_thru_carry, 1'b0, 1'b0);
    chk8(resultData, 8'hA5);
    chk1(carryFlag, 1'b1);
  endtask : rotate_nine

  // left rotate with carry cleared acts as a plain left shift
  task automatic rotate_left;
    load(8'h00, 8'h81);
    setc(1'b0);
    op(sca_pkg::rotate_left_thru_carry, 1'b0, 1'b0);
    chk8(resultData, 8'h02);
    chk1(carryFlag, 1'b1);
    @(posedge ref_clk);
    #1;
    chk1(resultValid, 1'b0);
    chk8(fileReg, 8'h02);
    op(sca_pkg::rotate_left_thru_carry, 1'b0, 1'b0);
    chk8(resultData, 8'h05);
    chk1(carryFlag, 1'b0);
  endtask : rotate_left

  // 16-bit add and subtract chained through the carry flag
  task automatic chains;
    load(8'hFF, 8'h01);
    setc(1'b0);
    op(sca_pkg::add_with_carry_op, 1'b0, 1'b0);
    chk8(resultData, 8'h00);
    chk1(carryFlag, 1'b1);
    chk1(zeroFlag, 1'b1);
    load(8'h12, 8'h01);
    op(sca_pkg::add_with_carry_op, 1'b0, 1'b0);
    chk8(resultData, 8'h14);
    chk1(carryFlag, 1'b0);
    load(8'h01, 8'h00);
    setc(1'b1);
    op(sca_pkg::sub_with_borrow_op, 1'b0, 1'b0);
    chk8(resultData, 8'hFF);
    chk1(carryFlag, 1'b0);
    load(8'h00, 8'h01);
    op(sca_pkg::sub_with_borrow_op, 1'b0, 1'b1);
    chk8(resultData, 8'h00);
    chk1(carryFlag, 1'b1);
    chk1(writeWorking, 1'b1);
  endtask : chains

  // working register as its own operand and destination
  task automatic work_alias;
    load(8'h81, 8'h3C);
    op(sca_pkg::logic_right_shift_op, 1'b1, 1'b0);
    chk8(resultData, 8'h40);
    chk1(carryFlag, 1'b1);
    chk1(writeWorking, 1'b1);
    chk1(writeFile, 1'b0);
    @(posedge ref_clk);
    #1;
    chk8(workReg, 8'h40);
  endtask : work_alias

  // reset in mid-run clears result, carry and strobes; then work resumes
  task automatic reset_mid;
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk8(resultData, sca_pkg::RESULT_RESET);
    chk1(carryFlag, sca_pkg::CARRY_RESET);
    chk1(resultValid, 1'b0);
    op(sca_pkg::rotate_left_thru_carry, 1'b0, 1'b0);
    chk8(resultData, 8'h00);
    chk1(zeroFlag, 1'b1);
  endtask : reset_mid

  task automatic summarize;
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  // main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk8(resultData, sca_pkg::RESULT_RESET);
    chk1(carryFlag, sca_pkg::CARRY_RESET);
    shift_table();
    rotate_nine();
    rotate_left();
    chains();
    work_alias();
    reset_mid();
    summarize();
  end

  // hang guard, far above the some 120 cycles the run needs
  initial begin
    #(3000 * 50);
    fail_count++;
    summarize();
  end
endmodule : tb
